//--- verilog/fspa_defs.svh
// Constants for the flash self-program access control block.
`ifndef FSPA_DEFS_SVH
`define FSPA_DEFS_SVH
`define FSPA_AW 13
`define FSPA_STALL_START 13'h1c00
`define FSPA_BOOT_START_3 13'h1f80
`define FSPA_BOOT_START_2 13'h1f00
`define FSPA_BOOT_START_1 13'h1e00
`define FSPA_BOOT_START_0 13'h1c00
`define FSPA_PG_LSB 6
`define FSPA_REG_CTRL 2'h0
`define FSPA_REG_STAT 2'h1
`define FSPA_REG_MASK 2'h2
`define FSPA_CTRL_EN 0
`define FSPA_CTRL_ERS 1
`define FSPA_CTRL_WRT 2
`define FSPA_CTRL_REEN 4
`define FSPA_CTRL_BUSY 6
`define FSPA_CTRL_WMASK 8'h07
`define FSPA_EV_DONE 0
`define FSPA_EV_REFUSE 1
`define FSPA_EV_BADRD 2
`define FSPA_EV_W 3
`define FSPA_LOCK_WR 0
`endif

//--- verilog/fspa_pkg.sv
// Types shared by the flash self-program access control block.
package fspa_pkg;
  typedef struct packed {
    logic [1:0] boot_size_fuses;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
  } fspa_fuse_t;
  typedef struct packed {
    logic erase;
    logic write;
    logic [6:0] page;
  } fspa_cmd_t;
  typedef enum logic [0:0] {
    FSPA_IDLE = 1'b0,
    FSPA_RUN = 1'b1
  } fspa_state_t;
endpackage

//--- verilog/fspa_top.sv
// Access control and CPU stall logic for flash self-programming.
`timescale 1ns/10ps
`include "fspa_defs.svh"

module fspa_top (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Register port.
  input wire logic [1:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Fuse and lock pins.
  input wire fspa_pkg::fspa_fuse_t FUSE_I,
  // CPU core side.
  input wire logic SPM_REQ_I,
  input wire logic [`FSPA_AW-1:0] SPM_PC_I,
  input wire logic [`FSPA_AW-1:0] SPM_TGT_I,
  input wire logic FETCH_REQ_I,
  input wire logic [`FSPA_AW-1:0] FETCH_ADDR_I,
  output logic CPU_HALT_O,
  output logic CONC_BLOCK_O,
  // Flash array side.
  output fspa_pkg::fspa_cmd_t ARR_CMD_O,
  input wire logic ARR_DONE_I,
  // Interrupt.
  output logic IRQ_O
);
  import fspa_pkg::*;

  fspa_fuse_t fuse_s1_q;
  fspa_fuse_t fuse_q;
  fspa_state_t st_q, st_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic busy_q, busy_d;
  logic halt_q, halt_d;
  fspa_cmd_t cmd_q, cmd_d;
  logic [`FSPA_EV_W-1:0] stat_q, stat_d;
  logic [`FSPA_EV_W-1:0] mask_q, mask_d;
  logic [`FSPA_EV_W-1:0] ev;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [`FSPA_AW-1:0] boot_start;
  logic pc_in_boot;
  logic tgt_in_boot;
  logic tgt_conc;
  logic want_op;
  logic locked;
  logic start_ok;
  logic page_load;
  logic reen_wr;

  // Fuse and lock pins come from outside the clock domain and pass two flops.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fuse_s1_q <= '0;
      fuse_q <= '0;
    end else begin
      fuse_s1_q <= FUSE_I;
      fuse_q <= fuse_s1_q;
    end
  end

  // Boot section start from the size fuses; every start is in the stalling section.
  always_comb begin
    case (fuse_q.boot_size_fuses)
      2'h3: boot_start = `FSPA_BOOT_START_3;
      2'h2: boot_start = `FSPA_BOOT_START_2;
      2'h1: boot_start = `FSPA_BOOT_START_1;
      default: boot_start = `FSPA_BOOT_START_0;
    endcase
  end

  // Section decode of the executing instruction and of the target page.
  assign pc_in_boot = (SPM_PC_I >= boot_start);
  assign tgt_in_boot = (SPM_TGT_I >= boot_start);
  assign tgt_conc = (SPM_TGT_I < `FSPA_STALL_START);
  assign want_op = ctrl_q[`FSPA_CTRL_EN] & (ctrl_q[`FSPA_CTRL_ERS] | ctrl_q[`FSPA_CTRL_WRT]);
  // A programmed write-lock bit of the section holding the target forbids the op.
  assign locked = tgt_in_boot ? ~fuse_q.boot_lock[`FSPA_LOCK_WR] :
                  ~fuse_q.app_lock[`FSPA_LOCK_WR];
  assign start_ok = SPM_REQ_I & (st_q == FSPA_IDLE) & pc_in_boot & want_op & ~locked;
  assign page_load = SPM_REQ_I & (st_q == FSPA_IDLE) & pc_in_boot & ctrl_q[`FSPA_CTRL_EN] & ~want_op;
  assign reen_wr = REG_WR_I & (REG_ADDR_I == `FSPA_REG_CTRL) & REG_WDATA_I[`FSPA_CTRL_REEN];

  // Next-state logic for the sequencer, the registers and the interrupt.
  always_comb begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    busy_d = busy_q;
    halt_d = halt_q;
    cmd_d = '0;
    stat_d = stat_q;
    mask_d = mask_q;
    rdata_d = '0;
    ev = '0;
    // Register writes; status bits clear when written with one.
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        `FSPA_REG_CTRL: ctrl_d = REG_WDATA_I & `FSPA_CTRL_WMASK;
        `FSPA_REG_STAT: stat_d = stat_q & ~REG_WDATA_I[`FSPA_EV_W-1:0];
        `FSPA_REG_MASK: mask_d = REG_WDATA_I[`FSPA_EV_W-1:0];
        default: ;
      endcase
    end
    // Register reads answer in the following cycle; unmapped reads give zero.
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `FSPA_REG_CTRL: begin
          rdata_d = ctrl_q;
          rdata_d[`FSPA_CTRL_BUSY] = busy_q;
        end
        `FSPA_REG_STAT: rdata_d = 8'(stat_q);
        `FSPA_REG_MASK: rdata_d = 8'(mask_q);
        default: rdata_d = '0;
      endcase
    end
    // Re-enable after completion, or a page load, clears the busy flag.
    if ((reen_wr && st_q == FSPA_IDLE) || page_load) begin
      busy_d = 1'b0;
    end
    case (st_q)
      FSPA_IDLE: begin
        if (SPM_REQ_I) begin
          // The op bits are consumed by every instruction issued while idle, taken or not.
          ctrl_d[`FSPA_CTRL_EN] = 1'b0;
          ctrl_d[`FSPA_CTRL_ERS] = 1'b0;
          ctrl_d[`FSPA_CTRL_WRT] = 1'b0;
          if (!pc_in_boot || (want_op && locked)) begin
            ev[`FSPA_EV_REFUSE] = 1'b1;
          end
          if (start_ok) begin
            // Whole-page command to the array.
            cmd_d.erase = ctrl_q[`FSPA_CTRL_ERS];
            cmd_d.write = ctrl_q[`FSPA_CTRL_WRT] & ~ctrl_q[`FSPA_CTRL_ERS];
            cmd_d.page = SPM_TGT_I[`FSPA_AW-1:`FSPA_PG_LSB];
            st_d = FSPA_RUN;
            if (tgt_conc) begin
              busy_d = 1'b1;
            end else begin
              halt_d = 1'b1;
            end
          end
        end
      end
      FSPA_RUN: begin
        if (ARR_DONE_I) begin
          st_d = FSPA_IDLE;
          halt_d = 1'b0;
          ev[`FSPA_EV_DONE] = 1'b1;
        end
      end
      default: st_d = FSPA_IDLE;
    endcase
    // A fetch or load from the blocked concurrent section is flagged.
    if (FETCH_REQ_I && busy_q && FETCH_ADDR_I < `FSPA_STALL_START) begin
      ev[`FSPA_EV_BADRD] = 1'b1;
    end
    // Events set after any clear, so a set in the clearing cycle wins.
    stat_d = stat_d | ev;
    irq_d = |(stat_d & mask_d);
  end

  // State registers.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= FSPA_IDLE;
      ctrl_q <= '0;
      busy_q <= 1'b0;
      halt_q <= 1'b0;
      cmd_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      busy_q <= busy_d;
      halt_q <= halt_d;
      cmd_q <= cmd_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // Outputs come straight from flops; the block flag is the busy flag itself.
  assign REG_RDATA_O = rdata_q;
  assign CPU_HALT_O = halt_q;
  assign CONC_BLOCK_O = busy_q;
  assign ARR_CMD_O = cmd_q;
  assign IRQ_O = irq_q;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_start_conc;
    start_ok && tgt_conc;
  endsequence

  sequence s_start_stall;
    start_ok && !tgt_conc;
  endsequence

  a_refuse_app_spm: assert property (
    (SPM_REQ_I && st_q == FSPA_IDLE && !pc_in_boot) |=> (st_q == FSPA_IDLE && !cmd_q.erase && !cmd_q.write)
  ) else $error("Store-program from application section took effect.");

  a_boot_any_page: assert property (
    start_ok |=> (st_q == FSPA_RUN && cmd_q.page == 7'($past(SPM_TGT_I) >> `FSPA_PG_LSB))
  ) else $error("Boot store-program did not reach its target page.");

  a_lock_refuses: assert property (
    (SPM_REQ_I && st_q == FSPA_IDLE && pc_in_boot && want_op && locked) |=> (st_q == FSPA_IDLE && stat_q[`FSPA_EV_REFUSE])
  ) else $error("Locked section write was not refused.");

  a_boot_in_stall: assert property (
    boot_start >= `FSPA_STALL_START
  ) else $error("Boot section reaches below the stalling section.");

  a_conc_runs_cpu: assert property (
    s_start_conc |=> (busy_q && !CPU_HALT_O) [*2]
  ) else $error("Concurrent-section programming stalled the CPU.");

  a_stall_holds: assert property (
    s_start_stall |=> (CPU_HALT_O until_with (st_q == FSPA_RUN && ARR_DONE_I))
  ) else $error("CPU halt dropped before the operation ended.");

  a_halt_release: assert property (
    (st_q == FSPA_RUN && ARR_DONE_I) |=> (!CPU_HALT_O && st_q == FSPA_IDLE && stat_q[`FSPA_EV_DONE])
  ) else $error("Halt not released at operation end.");

  a_busy_sticky: assert property (
    (busy_q && !reen_wr && !page_load) |=> busy_q
  ) else $error("Busy flag cleared without software action.");

  a_busy_reads: assert property (
    (REG_RD_I && REG_ADDR_I == `FSPA_REG_CTRL) |=> (REG_RDATA_O[`FSPA_CTRL_BUSY] == $past(busy_q))
  ) else $error("Busy flag read back wrong.");

  a_load_clears: assert property (
    page_load |=> !busy_q
  ) else $error("Page load did not clear the busy flag.");

  a_irq_follows: assert property (
    (stat_q & mask_q) != '0 |-> IRQ_O
  ) else $error("Interrupt low with an unmasked status bit.");

  // Checks on the page command, the busy flag, the blocked-read flag, the halt and the read port.
  a_cmd_one_pulse: assert property (
    (cmd_q.erase || cmd_q.write) |=> !(cmd_q.erase || cmd_q.write)
  ) else $error("Page command lasted more than one cycle.");

  a_erase_wins: assert property (
    (start_ok && ctrl_q[`FSPA_CTRL_ERS]) |=> (cmd_q.erase && !cmd_q.write)
  ) else $error("Erase request did not give a page erase.");

  a_write_only_cmd: assert property (
    (start_ok && !ctrl_q[`FSPA_CTRL_ERS]) |=> (cmd_q.write && !cmd_q.erase)
  ) else $error("Write request did not give a page write.");

  a_reen_clears: assert property (
    (reen_wr && st_q == FSPA_IDLE && !(start_ok && tgt_conc)) |=> !busy_q
  ) else $error("Re-enable write did not clear the busy flag.");

  a_stall_halts: assert property (
    s_start_stall |=> (CPU_HALT_O && st_q == FSPA_RUN)
  ) else $error("Stalling-section start did not halt the CPU.");

  a_badrd_flags: assert property (
    (FETCH_REQ_I && busy_q && FETCH_ADDR_I < `FSPA_STALL_START) |=> stat_q[`FSPA_EV_BADRD]
  ) else $error("Blocked concurrent-section read was not flagged.");

  a_halt_idle_low: assert property (
    (st_q == FSPA_IDLE) |-> !CPU_HALT_O
  ) else $error("CPU halted while no operation runs.");

  a_read_idle_zero: assert property (
    !REG_RD_I |=> (REG_RDATA_O == '0)
  ) else $error("Read data not zero outside a read answer.");
endmodule

//--- tb/fspa_array_model.sv
// Flash array stand-in that answers each page command after a fixed delay.
`timescale 1ns/10ps
module fspa_array_model #(
  parameter int DLY = 6
) (
  input wire logic clk_i,
  input wire fspa_pkg::fspa_cmd_t cmd_i,
  output logic done_o
);
  int cnt = 0;
  // Each erase or write acts on a whole page and ends with one done pulse.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (cmd_i.erase || cmd_i.write) begin
      cnt <= DLY;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the flash self-program access control block.
`timescale 1ns/10ps
`include "fspa_defs.svh"
module testbench;
  import fspa_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic store_program_instruction = 1'b0;
  logic fet = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [12:0] pc = 13'h0000;
  logic [12:0] tgt = 13'h0000;
  logic [12:0] faddr = 13'h0000;
  fspa_fuse_t fuse = 6'h3f;
  fspa_cmd_t cmd;
  logic halt, blk, done, irq;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h00002be5;
  fspa_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .FUSE_I(fuse), .SPM_REQ_I(store_program_instruction), .SPM_PC_I(pc), .SPM_TGT_I(tgt),
    .FETCH_REQ_I(fet), .FETCH_ADDR_I(faddr), .CPU_HALT_O(halt), .CONC_BLOCK_O(blk), .ARR_CMD_O(cmd),
    .ARR_DONE_I(done), .IRQ_O(irq));
  fspa_array_model #(.DLY(6)) arr (.clk_i(clk), .cmd_i(cmd), .done_o(done));
  // Clock at 20 MHz.
  initial begin
    forever #25 clk = ~clk;
  end
  // Repeatable random source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // First boot word for each boot size setting.
  function automatic logic [12:0] boot_start(input logic [1:0] f);
    case (f)
      2'h3: return 13'h1f80;
      2'h2: return 13'h1f00;
      2'h1: return 13'h1e00;
      default: return 13'h1c00;
    endcase
  endfunction
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles, one strobe cycle each.
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(exp));
  endtask
  task automatic fetch(input logic [12:0] a);
    @(posedge clk);
    fet <= 1'b1;
    faddr <= a;
    @(posedge clk);
    fet <= 1'b0;
  endtask
  // Issues one store-program request and follows it to completion.
  task automatic run_spm(input logic [12:0] p, input logic [12:0] t, input logic ers, input logic ok);
    logic stall;
    stall = ok && (t >= 13'h1c00);
    wreg(`FSPA_REG_CTRL, ers ? 8'h03 : 8'h05);
    @(posedge clk);
    store_program_instruction <= 1'b1;
    pc <= p;
    tgt <= t;
    @(posedge clk);
    store_program_instruction <= 1'b0;
    #1 chk(16'(cmd), ok ? 16'({ers, !ers, t[12:6]}) : 16'h0000);
    chk(16'(halt), 16'(stall));
    chk(16'(blk), 16'(ok && !stall));
    for (int i = 0; i < 40 && ok && !done; i++) begin
      @(posedge clk);
      #1 chk(16'(halt), 16'(stall));
    end
    repeat (2) @(posedge clk);
    #1 chk(16'(halt), 16'h0000);
    chk(16'(blk), 16'(ok && !stall));
  endtask
  // Page load: enable alone, issued from the boot section; no array command follows.
  task automatic page_ld(input logic [12:0] p);
    wreg(`FSPA_REG_CTRL, 8'h01);
    @(posedge clk);
    store_program_instruction <= 1'b1;
    pc <= p;
    @(posedge clk);
    store_program_instruction <= 1'b0;
    #1 chk(16'(cmd), 16'h0000);
  endtask
  // Main sequence over all boot sizes, with and without an application lock.
  initial begin
    logic [12:0] b;
    logic [12:0] t;
    logic [31:0] r;
    logic ok;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(`FSPA_REG_CTRL, 8'h00);
    wreg(2'h3, 8'hff);
    rreg(2'h3, 8'h00);
    wreg(`FSPA_REG_MASK, 8'h01);
    for (int k = 0; k < 8; k++) begin
      fuse <= {k[1:0], 1'b1, !k[2], 2'b11};
      repeat (3) @(posedge clk);
      b = boot_start(k[1:0]);
      r = rnd();
      run_spm(b - 13'h0001, b, r[0], 1'b0);
      rreg(`FSPA_REG_STAT, 8'h02);
      wreg(`FSPA_REG_STAT, 8'h07);
      // A stalling-section target below the boot start belongs to the application section and its lock.
      t = 13'h1c00 | 13'(r[15:6]);
      ok = !k[2] || (t >= b);
      run_spm(b | 13'(r[5:0]), t, r[1], ok);
      rreg(`FSPA_REG_STAT, ok ? 8'h01 : 8'h02);
      chk(16'(irq), 16'(ok));
      wreg(`FSPA_REG_STAT, 8'h07);
      // Software keeps interrupts off while the concurrent section is programmed.
      wreg(`FSPA_REG_MASK, 8'h00);
      t = 13'(r[31:16] % 16'h1c00);
      run_spm(b, t, r[2], !k[2]);
      chk(16'(irq), 16'h0000);
      if (!k[2]) begin
        fetch(13'h1c00 | 13'(r[9:0]));
        rreg(`FSPA_REG_STAT, 8'h01);
        fetch(t);
        rreg(`FSPA_REG_STAT, 8'h05);
        rreg(`FSPA_REG_CTRL, 8'h40);
        // Both ways of clearing the busy flag, in turn.
        if (k[0]) begin
          wreg(`FSPA_REG_CTRL, 8'h10);
        end else begin
          page_ld(b);
        end
        rreg(`FSPA_REG_CTRL, 8'h00);
      end else begin
        rreg(`FSPA_REG_STAT, 8'h02);
      end
      wreg(`FSPA_REG_STAT, 8'h07);
      wreg(`FSPA_REG_MASK, 8'h01);
      @(posedge clk);
      #1 chk(16'(irq), 16'h0000);
    end
    summarize();
  end
  // Cuts a hang short.
  initial begin
    #200000;
    fails++;
    summarize();
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule
